// *** core/tdm_highway_defines.vh ***
// register map, field positions, reset values and fixed counts of the
// highway offset control; included by the design files, defines only
`ifndef TDM_HIGHWAY_DEFINES_VH
`define TDM_HIGHWAY_DEFINES_VH

// register indices; byte address on apb is four times the index
`define IDX_TX_LOW_OFFSET   12'h68F
`define IDX_RX_LOW_OFFSET   12'h690
`define IDX_TX_EXT_CTRL     12'h6A1
`define IDX_RX_EXT_CTRL     12'h6A2
`define IDX_RESERVED_A      12'h6A3
`define IDX_RESERVED_B      12'h6A4
`define IDX_AUX_PATTERN     12'h6A5
`define IDX_STATUS          12'h6A6

// field positions
`define LOW_OFFSET_MSB      5
`define EXT_HIGH_BIT        0
`define EXT_DOUBLE_SLOT     1
`define ST_TX_RUN           0
`define ST_RX_RUN           1
`define ST_FIFO_EMPTY       2
`define ST_FIFO_FULL        3

// reset values
`define RST_LOW_OFFSET      6'h00
`define RST_EXT_CTRL        2'h0
`define RST_AUX_PATTERN     8'h00

// timing: bits per byte, and the word sent when the fifo runs dry
`define BYTE_SHIFT          3
`define IDLE_BYTE           8'hFF
`define SYNC_STAGES         3

`endif

// *** core/pin_sync.v ***
// three-stage synchroniser for pins from outside the clk domain
// assumes nothing of the pins; a change is passed on once stages two and
// three agree, so a single-cycle glitch at stage two is dropped
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 3
) (
  // system side
  input  wire             clk,
  input  wire             sys_rst,
  // raw pins and filtered levels
  input  wire [WIDTH-1:0] pin,
  output reg  [WIDTH-1:0] level
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer i;

  // stage1 feeds only stage2; the agreement check looks at stages 2 and 3
  always @(posedge clk) begin
    if (sys_rst) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
      level  <= {WIDTH{1'b0}};
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end
endmodule // pin_sync

// *** core/byte_fifo.v ***
// fifo memory for transmit bytes waiting for their highway slot
// assumes one clock; read data always come from a register, and a word
// written into the slot about to be read is passed straight through
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter AW    = 5
) (
  // system side
  input  wire             clk,
  input  wire             sys_rst,
  // filling side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // draining side
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data,
  // fill state
  output wire             empty,
  output wire             full
);
  localparam DEPTH = 1 << AW;

  reg  [WIDTH-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0]    wr_ptr;
  reg  [AW-1:0]    rd_ptr;
  reg  [AW:0]      count;
  wire             push;
  wire             pop;
  wire [AW-1:0]    next_rd;

  // honest flags: full only at DEPTH words, empty only at none
  assign full      = (count == DEPTH[AW:0]);
  assign empty     = (count == {(AW+1){1'b0}});
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign next_rd   = pop ? rd_ptr + 1'b1 : rd_ptr;

  // storage and registered read of the head word
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
    if (push && (wr_ptr == next_rd)) begin
      out_data <= in_data; // slot being written is the next head
    end else begin
      out_data <= mem[next_rd];
    end
  end

  // pointers and occupancy
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end else begin
      rd_ptr <= next_rd;
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (push & ~pop) begin
        count <= count + 1'b1;
      end else if (pop & ~push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// *** core/tdm_highway_offset_ctrl.v ***
// highway frame offset and double time-slot control, both directions
// assumes an apb master on clk, and a highway clock, frame sync and
// receive data that arrive from outside the clk domain at least 8 clk
// periods per highway clock period
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
`include "tdm_highway_defines.vh"

// How it works
// - transmit high bit adds 64 bytes between frame sync and transmit frame.
// - transmit offset is high bit plus six low bits, 0 to 127 bytes.
// - transmit double slot mode holds each data bit for two clocks.
// - receive high bit adds 64 bytes between frame sync and receive frame.
// - receive offset is high bit plus six low bits, 0 to 127 bytes.
// - receive double slot mode samples one bit per two highway clocks.
// - both extended controls and auxiliary pattern control reset to zero.
// - six low offset bits hold lower part of offset from frame sync.
module tdm_highway_offset_ctrl #(
  parameter FRAME_BYTES = 32,
  parameter BW          = 5,
  parameter FIFO_AW     = 5
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // transmit bytes from the user
  input  wire        tx_valid,
  output wire        tx_ready,
  input  wire [7:0]  tx_data,
  // receive bytes to the user
  output reg         rx_valid,
  output reg  [7:0]  rx_data,
  // concentration highway pins
  input  wire        highway_clock,
  input  wire        highway_frame_sync,
  input  wire        rx_highway_data,
  output reg         tx_highway_data,
  output reg         tx_highway_oe
);
  localparam ST_WAIT  = 3'b001;
  localparam ST_DELAY = 3'b010;
  localparam ST_RUN   = 3'b100;
  // index of the last byte of a frame, cut to the byte counter's width
  localparam [BW-1:0] LAST_BYTE = FRAME_BYTES[BW-1:0] - 1'b1;

  // software registers
  reg  [5:0]  tx_low_offset;
  reg  [5:0]  rx_low_offset;
  reg  [1:0]  tx_ext_ctrl;
  reg  [1:0]  rx_ext_ctrl;
  reg  [7:0]  aux_pattern_gen_ctrl;
  // settings in force for the current frame
  reg         act_tx_dts;
  reg         act_rx_dts;
  // highway sampling
  wire [2:0]  pin_level;
  reg         clk_level_d;
  wire        hw_edge;
  wire        fs_at_edge;
  wire        rx_line;
  // transmit path
  reg  [2:0]  tx_state;
  reg  [10:0] tx_cnt;
  reg         tx_half;
  reg  [2:0]  tx_bit;
  reg  [BW-1:0] tx_byte;
  reg  [7:0]  tx_shift;
  wire [10:0] tx_target;
  wire        tx_enter;
  wire        tx_advance;
  wire        tx_load;
  wire [7:0]  tx_next_byte;
  wire        fifo_valid;
  wire [7:0]  fifo_data;
  wire        fifo_empty;
  wire        fifo_full;
  // receive path
  reg  [2:0]  rx_state;
  reg  [10:0] rx_cnt;
  reg         rx_half;
  reg  [2:0]  rx_bit;
  reg  [BW-1:0] rx_byte;
  reg  [7:0]  rx_shift;
  wire [10:0] rx_target;
  wire        rx_enter;
  wire        rx_step;
  wire        cur_half;
  wire [2:0]  cur_bit;
  wire [BW-1:0] cur_byte;
  // apb decode
  wire [11:0] idx;
  wire        hit;
  wire        wr_en;

  // level pins through three flops each
  pin_sync #(
    .WIDTH (3)
  ) u_pin_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     ({rx_highway_data, highway_frame_sync, highway_clock}),
    .level   (pin_level)
  );

  // transmit bytes queue here; a full queue stalls the user
  byte_fifo #(
    .WIDTH (8),
    .AW    (FIFO_AW)
  ) u_byte_fifo (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (tx_valid),
    .in_ready  (tx_ready),
    .in_data   (tx_data),
    .out_valid (fifo_valid),
    .out_ready (tx_load),
    .out_data  (fifo_data),
    .empty     (fifo_empty),
    .full      (fifo_full)
  );

  // rising edge of the highway clock; sync and data share its pipeline
  always @(posedge clk) begin
    if (sys_rst) begin
      clk_level_d <= 1'b0;
    end else begin
      clk_level_d <= pin_level[0];
    end
  end
  assign hw_edge    = pin_level[0] & ~clk_level_d;
  assign fs_at_edge = hw_edge & pin_level[1];
  assign rx_line    = pin_level[2];

  // apb: zero wait states, unmapped indices answer with an error
  assign idx     = paddr[13:2];
  assign hit     = (idx == `IDX_TX_LOW_OFFSET) | (idx == `IDX_RX_LOW_OFFSET) |
                   (idx == `IDX_TX_EXT_CTRL)   | (idx == `IDX_RX_EXT_CTRL)   |
                   (idx == `IDX_RESERVED_A)    | (idx == `IDX_RESERVED_B)    |
                   (idx == `IDX_AUX_PATTERN)   | (idx == `IDX_STATUS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign wr_en   = psel & penable & pwrite & hit & pstrb[0];

  // register writes; reserved bits are not stored and read as zero
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_low_offset        <= `RST_LOW_OFFSET;
      rx_low_offset        <= `RST_LOW_OFFSET;
      tx_ext_ctrl          <= `RST_EXT_CTRL;
      rx_ext_ctrl          <= `RST_EXT_CTRL;
      aux_pattern_gen_ctrl <= `RST_AUX_PATTERN;
    end else if (wr_en) begin
      case (idx)
        `IDX_TX_LOW_OFFSET: tx_low_offset <= pwdata[`LOW_OFFSET_MSB:0];
        `IDX_RX_LOW_OFFSET: rx_low_offset <= pwdata[`LOW_OFFSET_MSB:0];
        `IDX_TX_EXT_CTRL:   tx_ext_ctrl   <= pwdata[1:0];
        `IDX_RX_EXT_CTRL:   rx_ext_ctrl   <= pwdata[1:0];
        `IDX_AUX_PATTERN:   aux_pattern_gen_ctrl <= pwdata[7:0];
        default: ; // reserved registers swallow writes
      endcase
    end
  end

  // read data captured in the setup cycle, held through the access
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (psel & ~penable) begin
      case (idx)
        `IDX_TX_LOW_OFFSET: prdata <= {26'h0000000, tx_low_offset};
        `IDX_RX_LOW_OFFSET: prdata <= {26'h0000000, rx_low_offset};
        `IDX_TX_EXT_CTRL:   prdata <= {30'h00000000, tx_ext_ctrl};
        `IDX_RX_EXT_CTRL:   prdata <= {30'h00000000, rx_ext_ctrl};
        `IDX_AUX_PATTERN:   prdata <= {24'h000000, aux_pattern_gen_ctrl};
        `IDX_STATUS:        prdata <= {28'h0000000, fifo_full, fifo_empty,
                                       rx_state == ST_RUN,
                                       tx_state == ST_RUN};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end

  // settings are copied only at frame sync, so a write mid-frame never
  // tears the current frame
  always @(posedge clk) begin
    if (sys_rst) begin
      act_tx_dts    <= 1'b0;
      act_rx_dts    <= 1'b0;
    end else if (fs_at_edge) begin
      act_tx_dts    <= tx_ext_ctrl[`EXT_DOUBLE_SLOT];
      act_rx_dts    <= rx_ext_ctrl[`EXT_DOUBLE_SLOT];
    end
  end

  // delay in highway clocks: bytes times 8, doubled in double slot mode;
  // the high bit is weight 64, so it adds 64 bytes
  assign tx_target = {1'b0, tx_ext_ctrl[`EXT_HIGH_BIT], tx_low_offset,
                      3'b000} << tx_ext_ctrl[`EXT_DOUBLE_SLOT];
  assign rx_target = {1'b0, rx_ext_ctrl[`EXT_HIGH_BIT], rx_low_offset,
                      3'b000} << rx_ext_ctrl[`EXT_DOUBLE_SLOT];

  // transmit: frame starts on the sync edge itself when offset is zero
  assign tx_enter   = hw_edge & ((fs_at_edge & (tx_target == 11'd0)) |
                      (~fs_at_edge & (tx_state == ST_DELAY) &
                       (tx_cnt == 11'd0)));
  assign tx_advance = hw_edge & ~fs_at_edge & (tx_state == ST_RUN) &
                      ~(act_tx_dts & ~tx_half);
  assign tx_load    = tx_enter | (tx_advance & (tx_bit == 3'd7) &
                      (tx_byte != LAST_BYTE));
  assign tx_next_byte = fifo_valid ? fifo_data : `IDLE_BYTE;

  // transmit sequencer
  always @(posedge clk) begin
    if (sys_rst) begin
      tx_state        <= ST_WAIT;
      tx_cnt          <= 11'd0;
      tx_half         <= 1'b0;
      tx_bit          <= 3'd0;
      tx_byte         <= {BW{1'b0}};
      tx_shift        <= 8'h00;
      tx_highway_data <= 1'b1;
      tx_highway_oe   <= 1'b0;
    end else if (tx_enter) begin
      tx_state        <= ST_RUN;
      tx_half         <= 1'b0;
      tx_bit          <= 3'd0;
      tx_byte         <= {BW{1'b0}};
      tx_shift        <= tx_next_byte;
      tx_highway_data <= tx_next_byte[7];
      tx_highway_oe   <= 1'b1;
    end else if (fs_at_edge) begin
      tx_state        <= ST_DELAY; // a new sync restarts the frame
      tx_cnt          <= tx_target - 11'd1;
      tx_highway_oe   <= 1'b0;
      tx_highway_data <= 1'b1; // idle level while released
    end else if (hw_edge) begin
      case (tx_state)
        ST_WAIT: ;
        ST_DELAY: tx_cnt <= tx_cnt - 11'd1;
        ST_RUN: begin
          if (act_tx_dts & ~tx_half) begin
            tx_half <= 1'b1; // bit held for a second clock
          end else begin
            tx_half <= 1'b0;
            tx_bit  <= tx_bit + 3'd1;
            if (tx_bit != 3'd7) begin
              tx_shift        <= {tx_shift[6:0], 1'b0};
              tx_highway_data <= tx_shift[6];
            end else if (tx_byte == LAST_BYTE) begin
              tx_state        <= ST_WAIT;
              tx_highway_oe   <= 1'b0;
              tx_highway_data <= 1'b1; // idle level after the frame
            end else begin
              tx_byte         <= tx_byte + 1'b1;
              tx_shift        <= tx_next_byte;
              tx_highway_data <= tx_next_byte[7];
            end
          end
        end
        default: tx_state <= ST_WAIT;
      endcase
    end
  end

  // receive: the entry edge is the first clock period of bit 0
  assign rx_enter = hw_edge & ((fs_at_edge & (rx_target == 11'd0)) |
                    (~fs_at_edge & (rx_state == ST_DELAY) &
                     (rx_cnt == 11'd0)));
  assign rx_step  = rx_enter | (hw_edge & ~fs_at_edge & (rx_state == ST_RUN));
  assign cur_half = rx_enter ? 1'b0 : rx_half;
  assign cur_bit  = rx_enter ? 3'd0 : rx_bit;
  assign cur_byte = rx_enter ? {BW{1'b0}} : rx_byte;

  // receive sequencer; in double slot mode the second clock samples, but the first does in a zero-offset frame whose sync turns the mode on
  always @(posedge clk) begin
    if (sys_rst) begin
      rx_state <= ST_WAIT;
      rx_cnt   <= 11'd0;
      rx_half  <= 1'b0;
      rx_bit   <= 3'd0;
      rx_byte  <= {BW{1'b0}};
      rx_shift <= 8'h00;
      rx_data  <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (rx_step) begin
        rx_state <= ST_RUN;
        rx_byte  <= cur_byte;
        rx_bit   <= cur_bit;
        if (act_rx_dts & ~cur_half) begin
          rx_half <= 1'b1; // first clock of a doubled bit
        end else begin
          rx_half  <= 1'b0;
          rx_bit   <= cur_bit + 3'd1;
          rx_shift <= {rx_shift[6:0], rx_line};
          if (cur_bit == 3'd7) begin
            rx_data  <= {rx_shift[6:0], rx_line};
            rx_valid <= 1'b1;
            rx_byte  <= cur_byte + 1'b1;
            if (cur_byte == LAST_BYTE) begin
              rx_state <= ST_WAIT;
            end
          end
        end
      end else if (fs_at_edge) begin
        rx_state <= ST_DELAY;
        rx_cnt   <= rx_target - 11'd1;
      end else if (hw_edge && rx_state == ST_DELAY) begin
        rx_cnt <= rx_cnt - 11'd1;
      end
    end
  end
endmodule // tdm_highway_offset_ctrl

// *** sim/tdm_highway_offset_ctrl_sva.sv ***
// checker for the highway offset control, on its top ports only
// assumes at least 8 clk periods per highway clock period
`timescale 1ns/1ps
`include "tdm_highway_defines.vh"
module tdm_highway_offset_ctrl_sva #(
  parameter FRAME_BYTES = 32
) (
  // clock, reset and apb
  input wire        clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [13:0] paddr,
  input wire [3:0]  pstrb,
  input wire [31:0] prdata,
  input wire        pslverr,
  // receive bytes and transmit pin
  input wire        rx_valid,
  input wire [7:0]  rx_data,
  input wire        tx_highway_data,
  input wire        tx_highway_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // jitter of the pin synchroniser may cost a cycle at each end
  localparam int MIN_LEN = FRAME_BYTES * 64 - 2;
  wire        rd  = psel && penable && !pwrite;
  wire [11:0] idx = paddr[13:2];
  wire        tx_e = idx == `IDX_TX_EXT_CTRL;
  wire        rx_e = idx == `IDX_RX_EXT_CTRL;
  wire        ax_e = idx == `IDX_AUX_PATTERN;
  reg  [2:0]  wrote;
  reg  [15:0] oe_len;
  // control registers written since reset
  always @(posedge clk) begin
    if (sys_rst)
      wrote <= 3'h0;
    else if (psel && penable && pwrite && pstrb[0])
      wrote <= wrote | {ax_e, rx_e, tx_e};
  end
  // length of the current driven stretch
  always @(posedge clk) oe_len <= tx_highway_oe ? oe_len + 16'h1 : 16'h0;

  chk_rst_defaults: assert property (rd && ((tx_e && !wrote[0]) ||
    (rx_e && !wrote[1]) || (ax_e && !wrote[2])) |-> prdata == 32'h0)
    else $error("control register not zero after reset");
  chk_rsvd_zero: assert property (rd && (idx == `IDX_RESERVED_A ||
    idx == `IDX_RESERVED_B) |-> prdata == 32'h0 && !pslverr)
    else $error("reserved register not read as zero");
  chk_ext_bits: assert property (rd && (tx_e || rx_e)
    |-> prdata[31:2] == 30'h0) else $error("reserved bits not zero");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  chk_bit_hold: assert property ($changed(tx_highway_data)
    |=> $stable(tx_highway_data) [*6]) else $error("bit too short");
  chk_frame_len: assert property ($fell(tx_highway_oe)
    |-> oe_len >= MIN_LEN) else $error("frame ended early");
  chk_idle_mark: assert property (!tx_highway_oe
    |-> tx_highway_data) else $error("idle pin not high");
  chk_rx_spacing: assert property (rx_valid
    |=> !rx_valid [*8]) else $error("bytes too close");
  chk_rx_hold: assert property (!rx_valid |-> $stable(rx_data))
    else $error("receive byte changed without valid");
endmodule // tdm_highway_offset_ctrl_sva

// *** sim/highway_switch.sv ***
// far side of the highway: clock, frame sync and receive data, with a
// record of the transmit pin taken just before each highway rise
// assumes the bench loads rx_bit before it calls run_frame
`timescale 1ns/1ps
module highway_switch (
  // system clock, for idle noise only
  input  wire clk,
  // highway pins
  input  wire tx_highway_data,
  input  wire tx_highway_oe,
  output reg  highway_clock,
  output reg  highway_frame_sync,
  output reg  rx_highway_data
);
  reg     rx_bit  [0:2047];
  reg     tx_seen [0:2047];
  reg     oe_seen [0:2047];
  reg     active;
  integer r;
  initial begin
    highway_clock = 1'b0;
    highway_frame_sync = 1'b0;
    rx_highway_data = 1'b0;
    active = 1'b0;
  end
  // no stale level between frames: the line keeps changing
  always @(posedge clk) if (!active) rx_highway_data <= ~rx_highway_data;
  // n highway rises at 320 ns, rise 0 carries the sync; clock stands still
  // outside frames
  task run_frame(input integer n);
    begin
      active = 1'b1;
      #13;
      for (r = 0; r < n; r = r + 1) begin
        highway_frame_sync = (r == 0);
        rx_highway_data = rx_bit[r];
        #160;
        tx_seen[r] = tx_highway_data;
        oe_seen[r] = tx_highway_oe;
        highway_clock = 1'b1;
        #160;
        highway_clock = 1'b0;
      end
      highway_frame_sync = 1'b0;
      active = 1'b0;
    end
  endtask
endmodule // highway_switch

// *** sim/tdm_highway_offset_ctrl_test.sv ***
// bench for the highway offset control: registers over apb, fifo fill,
// and frames at several offsets through the highway partner
// assumes frames cut to 4 bytes to keep the run short
`timescale 1ns/1ps
`include "tdm_highway_defines.vh"
module tdm_highway_offset_ctrl_test;
  localparam FB = 4;
  reg         clk, sys_rst, psel, penable, pwrite, tx_valid, e;
  reg  [13:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [3:0]  pstrb;
  reg  [7:0]  tx_data;
  wire [31:0] prdata;
  wire [7:0]  rx_data;
  wire        pready, pslverr, tx_ready, rx_valid, tx_highway_data;
  wire        tx_highway_oe, highway_clock, highway_frame_sync;
  wire        rx_highway_data;
  integer     fails, n_tests, i;
  reg  [7:0]  txq [$];
  reg  [7:0]  rxq [$];

  tdm_highway_offset_ctrl #(.FRAME_BYTES(FB)) u_dut (.clk(clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
    .rx_data(rx_data), .highway_clock(highway_clock),
    .highway_frame_sync(highway_frame_sync),
    .rx_highway_data(rx_highway_data), .tx_highway_data(tx_highway_data),
    .tx_highway_oe(tx_highway_oe));
  highway_switch u_hw (.clk(clk), .tx_highway_data(tx_highway_data),
    .tx_highway_oe(tx_highway_oe), .highway_clock(highway_clock),
    .highway_frame_sync(highway_frame_sync),
    .rx_highway_data(rx_highway_data));

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // collect received bytes
  always @(posedge clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

  task chk(input string nm, input [31:0] x, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        fails = fails + 1;
        $display("wrong value %s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  // one apb transfer, held until pready is seen high
  task apb(input w, input [11:0] a, input [31:0] d, input [3:0] s);
    integer n;
    begin
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {a, 2'b00};
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      @(posedge clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 20) begin
        fails = fails + 1;
        tally_and_finish;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task rd(input string nm, input [11:0] a, input [31:0] x, input xe);
    begin
      apb(1'b0, a, 32'h0, 4'h0);
      chk(nm, x, q);
      chk(nm, {31'h0, xe}, {31'h0, e});
    end
  endtask
  task t_reset;
    begin
      rd("tx ext", `IDX_TX_EXT_CTRL, 32'h0, 1'b0);
      rd("rx ext", `IDX_RX_EXT_CTRL, 32'h0, 1'b0);
      rd("aux", `IDX_AUX_PATTERN, 32'h0, 1'b0);
      rd("status", `IDX_STATUS, 32'h4, 1'b0);
      rd("unmapped", 12'h001, 32'h0, 1'b1);
      $display("reset test done");
    end
  endtask
  task t_regs;
    begin
      apb(1'b1, `IDX_AUX_PATTERN, 32'hA5, 4'hF);
      apb(1'b1, `IDX_AUX_PATTERN, 32'h5A, 4'hE);
      rd("aux", `IDX_AUX_PATTERN, 32'hA5, 1'b0);
      apb(1'b1, `IDX_RESERVED_A, 32'h0, 4'hF);
      apb(1'b1, `IDX_RESERVED_B, 32'h0, 4'hF);
      rd("rsvd a", `IDX_RESERVED_A, 32'h0, 1'b0);
      rd("rsvd b", `IDX_RESERVED_B, 32'h0, 1'b0);
      $display("register test done");
    end
  endtask
  // fill the fifo until it refuses; byte 32 is offered and must be dropped
  task t_fill;
    begin
      for (i = 0; i < 33; i = i + 1) begin
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_data <= 8'h40 + i[7:0];
        if (i < 32) txq.push_back(8'h40 + i[7:0]);
      end
      @(posedge clk);
      tx_valid <= 1'b0;
      chk("tx ready full", 32'h0, {31'h0, tx_ready});
      rd("status full", `IDX_STATUS, 32'h8, 1'b0);
      $display("fill test done");
    end
  endtask
  // one frame with the same settings on both directions
  task t_frame(input hi, input [5:0] lo, input dbl);
    integer k, m, j;
    reg [7:0] xb [0:FB-1];
    reg [7:0] rb;
    begin
      m = dbl ? 2 : 1;
      k = {hi, lo} * 8 * m;
      apb(1'b1, `IDX_TX_LOW_OFFSET, {26'h0, lo}, 4'hF);
      apb(1'b1, `IDX_RX_LOW_OFFSET, {26'h0, lo}, 4'hF);
      apb(1'b1, `IDX_TX_EXT_CTRL, {30'h0, dbl, hi}, 4'hF);
      apb(1'b1, `IDX_RX_EXT_CTRL, {30'h0, dbl, hi}, 4'hF);
      for (j = 0; j < 2048; j = j + 1) u_hw.rx_bit[j] = j[0];
      for (j = 0; j < FB; j = j + 1)
        xb[j] = (txq.size() > 0) ? txq.pop_front() : 8'hFF;
      for (j = 0; j < FB * 8 * m; j = j + 1) begin
        rb = 8'h3C + j[7:0] / (8 * m) * 8'h21 + k[7:0];
        u_hw.rx_bit[k + j] = rb[7 - (j / m) % 8];
      end
      rxq.delete();
      u_hw.run_frame(k + FB * 8 * m + 2);
      chk("oe before", 32'h0, u_hw.oe_seen[k]);
      for (j = 0; j < FB * 8 * m; j = j + 1) begin
        rb = xb[j / (8 * m)];
        chk("tx bit", rb[7 - (j / m) % 8], u_hw.tx_seen[k + j + 1]);
        chk("tx oe", 32'h1, u_hw.oe_seen[k + j + 1]);
      end
      chk("oe after", 32'h0, u_hw.oe_seen[k + FB * 8 * m + 1]);
      j = 0;
      while (rxq.size() < FB && j < 100) begin
        @(posedge clk);
        j = j + 1;
      end
      chk("rx count", FB, rxq.size());
      for (j = 0; j < FB && rxq.size() > 0; j = j + 1) begin
        rb = 8'h3C + j[7:0] * 8'h21 + k[7:0];
        chk("rx byte", rb, rxq.pop_front());
      end
      $display("frame test done, offset %0d", k);
    end
  endtask

  initial begin
    fails = 0;
    n_tests = 0;
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset;
    t_regs;
    t_fill;
    t_frame(1'b0, 6'h00, 1'b0);
    t_frame(1'b0, 6'h05, 1'b0);
    t_frame(1'b1, 6'h00, 1'b0);
    t_frame(1'b1, 6'h3F, 1'b0);
    t_frame(1'b0, 6'h01, 1'b1);
    t_frame(1'b1, 6'h02, 1'b1);
    t_frame(1'b0, 6'h3F, 1'b0);
    t_frame(1'b0, 6'h00, 1'b1);
    rd("status empty", `IDX_STATUS, 32'h4, 1'b0);
    t_frame(1'b0, 6'h03, 1'b0);
    tally_and_finish;
  end
endmodule // tdm_highway_offset_ctrl_test

bind tdm_highway_offset_ctrl tdm_highway_offset_ctrl_sva #(
  .FRAME_BYTES(FRAME_BYTES)) u_sva (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr),
  .rx_valid(rx_valid), .rx_data(rx_data),
  .tx_highway_data(tx_highway_data), .tx_highway_oe(tx_highway_oe));
